// file: logic/chgst_regs.svh
// Purpose: Offsets, field positions and reset values of the charger status registers
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only; types live in chgst_pkg
`ifndef CHGST_REGS_SVH
`define CHGST_REGS_SVH

// Register offsets on the register interface
`define CHGST_LIVE_OFS     8'h00
`define CHGST_FAULT_OFS    8'h01

// Live status field positions
`define CHGST_OPEN_BIT     7
`define CHGST_PHASE_HI     6
`define CHGST_PHASE_LO     5
`define CHGST_ILIM_BIT     4
`define CHGST_DIP_BIT      3
`define CHGST_VIN_BIT      2
`define CHGST_THERM_BIT    1
`define CHGST_PGOOD_BIT    0

// Fault status field positions
`define CHGST_OVP_BIT      7
`define CHGST_BUVLO_BIT    6
`define CHGST_RSVD_BIT     5
`define CHGST_ZONE_HI      4
`define CHGST_ZONE_LO      3
`define CHGST_SAFETY_BIT   2
`define CHGST_WAKE1_BIT    1
`define CHGST_WAKE2_BIT    0

// Widths and reset values
`define CHGST_FLAG_COUNT   3
`define CHGST_FLAG_RESET   3'h0
`define CHGST_DATA_RESET   8'h00
`define CHGST_UNMAPPED     8'h00

`endif

// file: logic/chgst_pkg.sv
// Purpose: Types shared by the charger status register bank
// Assumes: Constants come from chgst_regs.svh
// Notes:   Enum codes equal the register encodings
package chgst_pkg;

	// Charge phase as reported in the live register
	typedef enum logic [1:0] {
		CHGST_PH_IDLE = 2'h0,
		CHGST_PH_CC   = 2'h1,
		CHGST_PH_CV   = 2'h2,
		CHGST_PH_DONE = 2'h3
	} chgst_phase_t;

	// Thermistor zone as reported in the fault register
	typedef enum logic [1:0] {
		CHGST_TZ_NORMAL  = 2'h0,
		CHGST_TZ_SUSPEND = 2'h1,
		CHGST_TZ_COOL    = 2'h2,
		CHGST_TZ_WARM    = 2'h3
	} chgst_zone_t;

	// Pin-level conditions, all asynchronous to clk
	typedef struct packed {
		logic thermistor_pin_open;
		logic input_current_limiting;
		logic supply_dip_limiting;
		logic input_voltage_limiting;
		logic thermal_regulating;
		logic input_power_good;
		logic input_overvoltage;
		logic battery_undervoltage;
		logic charge_enable;
	} chgst_pins_t;

	// Whole state of the top module
	typedef struct packed {
		chgst_pins_t sync1;
		chgst_pins_t sync2;
		logic        ce_prev;
		logic [2:0]  ce_arm;
		logic [7:0]  rdata;
		logic        rvalid;
	} chgst_top_state_t;

	// Whole state of the flag module
	typedef struct packed {
		logic [2:0] flags;
	} chgst_flag_state_t;

endpackage : chgst_pkg

// file: logic/chgst_flag_if.sv
// Purpose: Carries set, clear and value of the sticky flags
// Assumes: All signals on the block clock
// Notes:   Bit order follows the fault register low bits
`timescale 1ns/1ps
`include "chgst_regs.svh"
interface chgst_flag_if;
	logic [`CHGST_FLAG_COUNT-1:0] set;   // Event pulses
	logic [`CHGST_FLAG_COUNT-1:0] clr;   // Clear pulses
	logic [`CHGST_FLAG_COUNT-1:0] q;     // Flag values

	// Flag keeper side
	modport owner (input set, input clr, output q);
	// Register side
	modport user (output set, output clr, input q);
endinterface : chgst_flag_if

// file: logic/chgst_flag.sv
// Purpose: Sticky flags of the fault register
// Assumes: Set and clear are one-cycle pulses on clk
// Notes:   Set beats clear in the same cycle so no event is lost
`timescale 1ns/1ps
`include "chgst_regs.svh"
module chgst_flag (
	// Clock, reset, enable
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        clk_en,
	// Flag carrier
	chgst_flag_if.owner     fl
);
	chgst_pkg::chgst_flag_state_t st;       // Registered state
	chgst_pkg::chgst_flag_state_t next_st;  // Next state

	// Per-bit update, set wins over clear
	always_comb begin
		next_st = st;
		for (int i = 0; i < `CHGST_FLAG_COUNT; i++) begin
			next_st.flags[i] = fl.set[i] | (st.flags[i] & ~fl.clr[i]);
		end
	end

	// State register, reset takes priority over enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.flags <= `CHGST_FLAG_RESET;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign fl.q = st.flags;

	// Event always lands, even against a clear
	sequence s_evt(int b);
		clk_en && fl.set[b];
	endsequence
	chk_safety_sets: assert property (@(posedge clk) disable iff (!rst_n)
		s_evt(`CHGST_SAFETY_BIT) |=> fl.q[`CHGST_SAFETY_BIT])
		else $error("safety flag not set by expiry");
	chk_wake1_sets: assert property (@(posedge clk) disable iff (!rst_n)
		s_evt(`CHGST_WAKE1_BIT) |=> fl.q[`CHGST_WAKE1_BIT])
		else $error("wake one flag not set");
	chk_wake2_sets: assert property (@(posedge clk) disable iff (!rst_n)
		s_evt(`CHGST_WAKE2_BIT) |=> fl.q[`CHGST_WAKE2_BIT])
		else $error("wake two flag not set");
endmodule : chgst_flag

// file: logic/chgst_top.sv
// Purpose: Live and fault status registers of a one-cell charger, read through the register interface
// Assumes: Register strobes come from the serial slave on clk; condition pins are asynchronous
// Notes:   Read data is registered and valid one cycle after the read strobe
//
// Summary of operation
// - Live bit 7 shows thermistor pin open
// - Live bits 6-5 encode the charge phase
// - Live bits 4-1 show limiting and thermal regulation
// - Live bit 0 shows input power good
// - Fault bits 7-6 show overvoltage and undervoltage
// - Fault bits 4-3 encode the thermistor zone
// - Safety flag clears only on charge-enable toggle
// - Wake one flag sets on event, clears on read
// - Wake two flag sets on event, clears on read
// - Both registers readable at their offsets
`timescale 1ns/1ps
`include "chgst_regs.svh"
module chgst_top (
	// Clock, reset, enable
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 clk_en,
	// Register interface from the serial slave
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_rd,
	input  wire logic                 reg_wr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	output logic                      reg_rvalid,
	// Asynchronous condition pins
	input  wire logic                 thermistor_pin_open,
	input  wire logic                 input_current_limiting,
	input  wire logic                 supply_dip_limiting,
	input  wire logic                 input_voltage_limiting,
	input  wire logic                 thermal_regulating,
	input  wire logic                 input_power_good,
	input  wire logic                 input_overvoltage,
	input  wire logic                 battery_undervoltage,
	input  wire logic                 charge_enable,
	// Same-clock state from the charge controller
	input  wire chgst_pkg::chgst_phase_t charge_phase,
	input  wire chgst_pkg::chgst_zone_t  thermistor_zone,
	// Same-clock event pulses from the timers
	input  wire logic                 safety_timer_expired,
	input  wire logic                 first_wake_met,
	input  wire logic                 second_wake_met
);
	chgst_pkg::chgst_top_state_t st;       // Registered state
	chgst_pkg::chgst_top_state_t next_st;  // Next state
	chgst_pkg::chgst_pins_t      pins_in;  // Raw pins gathered
	logic                        ce_toggle; // Charge enable changed
	logic [1:0]                  sel;       // One-hot register select
	logic [7:0]                  live_val;  // Live register image
	logic [7:0]                  fault_val; // Fault register image

	// Flag carrier between this module and the flag keeper
	chgst_flag_if fl ();

	// Address decode, one-hot: bit 0 live, bit 1 fault
	function automatic logic [1:0] chgst_decode(input logic [7:0] a);
		logic [1:0] s;
		s = 2'h0;
		if (a == `CHGST_LIVE_OFS) begin
			s[0] = 1'b1;
		end
		if (a == `CHGST_FAULT_OFS) begin
			s[1] = 1'b1;
		end
		return s;
	endfunction : chgst_decode

	assign sel = chgst_decode(reg_addr);

	// Gather the asynchronous pins in one word
	always_comb begin
		pins_in.thermistor_pin_open    = thermistor_pin_open;
		pins_in.input_current_limiting = input_current_limiting;
		pins_in.supply_dip_limiting    = supply_dip_limiting;
		pins_in.input_voltage_limiting = input_voltage_limiting;
		pins_in.thermal_regulating     = thermal_regulating;
		pins_in.input_power_good       = input_power_good;
		pins_in.input_overvoltage      = input_overvoltage;
		pins_in.battery_undervoltage   = battery_undervoltage;
		pins_in.charge_enable          = charge_enable;
	end

	// Toggle of the synchronised charge enable, either direction
	// Held off until the chain and ce_prev hold real pin values, so a
	// high enable pin at reset release is not taken for a toggle
	assign ce_toggle = (st.sync2.charge_enable ^ st.ce_prev) & st.ce_arm[2];

	// Live register image, all fields follow their sources
	always_comb begin
		live_val = `CHGST_DATA_RESET;
		live_val[`CHGST_OPEN_BIT] = st.sync2.thermistor_pin_open;
		live_val[`CHGST_PHASE_HI:`CHGST_PHASE_LO] = charge_phase;
		live_val[`CHGST_ILIM_BIT]  = st.sync2.input_current_limiting;
		live_val[`CHGST_DIP_BIT]   = st.sync2.supply_dip_limiting;
		live_val[`CHGST_VIN_BIT]   = st.sync2.input_voltage_limiting;
		live_val[`CHGST_THERM_BIT] = st.sync2.thermal_regulating;
		live_val[`CHGST_PGOOD_BIT] = st.sync2.input_power_good;
	end

	// Fault register image; reserved bit stays zero
	always_comb begin
		fault_val = `CHGST_DATA_RESET;
		fault_val[`CHGST_OVP_BIT]   = st.sync2.input_overvoltage;
		fault_val[`CHGST_BUVLO_BIT] = st.sync2.battery_undervoltage;
		fault_val[`CHGST_ZONE_HI:`CHGST_ZONE_LO] = thermistor_zone;
		fault_val[`CHGST_SAFETY_BIT] = fl.q[`CHGST_SAFETY_BIT];
		fault_val[`CHGST_WAKE1_BIT]  = fl.q[`CHGST_WAKE1_BIT];
		fault_val[`CHGST_WAKE2_BIT]  = fl.q[`CHGST_WAKE2_BIT];
	end

	// Flag set and clear terms
	always_comb begin
		fl.set = {safety_timer_expired, first_wake_met, second_wake_met};
		fl.clr = 3'h0;
		// toggle is the only clear of the safety flag
		fl.clr[`CHGST_SAFETY_BIT] = ce_toggle;
		// read of the fault register clears the wake flags
		fl.clr[`CHGST_WAKE1_BIT] = reg_rd & sel[1];
		fl.clr[`CHGST_WAKE2_BIT] = reg_rd & sel[1];
	end

	// Sticky flag keeper; set beats clear there
	chgst_flag u_flag (
		.clk    (clk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.fl     (fl.owner)
	);

	// Next state: synchronisers and read answer
	always_comb begin
		next_st = st;
		// Two flops; the first is read only by the second
		next_st.sync1   = pins_in;
		next_st.sync2   = st.sync1;
		next_st.ce_prev = st.sync2.charge_enable;
		// Fills with ones over three enabled edges after reset
		next_st.ce_arm  = {st.ce_arm[1:0], 1'b1};
		next_st.rvalid  = reg_rd;
		if (reg_rd) begin
			unique case (sel)
				2'h1:    next_st.rdata = live_val;
				2'h2:    next_st.rdata = fault_val;
				// Unlisted offsets read as zero
				default: next_st.rdata = `CHGST_UNMAPPED;
			endcase
		end
		// writes fall through with no effect; reg_wdata is not stored
	end

	// State register, reset takes priority over enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// Data and strobe come straight from flops
	assign reg_rdata  = st.rdata;
	assign reg_rvalid = st.rvalid;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Read requests taken on an enabled edge
	sequence s_live_rd;
		clk_en && reg_rd && reg_addr == `CHGST_LIVE_OFS;
	endsequence
	sequence s_fault_rd;
		clk_en && reg_rd && reg_addr == `CHGST_FAULT_OFS;
	endsequence

	chk_open_bit: assert property (s_live_rd |=>
		reg_rdata[`CHGST_OPEN_BIT] == $past(st.sync2.thermistor_pin_open))
		else $error("open pin bit wrong");
	chk_phase_code: assert property (s_live_rd |=>
		reg_rdata[`CHGST_PHASE_HI:`CHGST_PHASE_LO] == $past(charge_phase))
		else $error("charge phase code wrong");
	chk_limit_bits: assert property (s_live_rd |=>
		reg_rdata[`CHGST_ILIM_BIT:`CHGST_THERM_BIT] == $past({st.sync2.input_current_limiting,
		st.sync2.supply_dip_limiting, st.sync2.input_voltage_limiting, st.sync2.thermal_regulating}))
		else $error("limiting bits wrong");
	chk_pgood_bit: assert property (s_live_rd |=>
		reg_rdata[`CHGST_PGOOD_BIT] == $past(st.sync2.input_power_good))
		else $error("power good bit wrong");
	chk_fault_levels: assert property (s_fault_rd |=>
		reg_rdata[`CHGST_OVP_BIT:`CHGST_RSVD_BIT] == {$past(st.sync2.input_overvoltage),
		$past(st.sync2.battery_undervoltage), 1'b0})
		else $error("fault level bits wrong");
	chk_zone_code: assert property (s_fault_rd |=>
		reg_rdata[`CHGST_ZONE_HI:`CHGST_ZONE_LO] == $past(thermistor_zone))
		else $error("thermistor zone wrong");
	chk_safety_hold: assert property (clk_en && fl.q[`CHGST_SAFETY_BIT] && !ce_toggle
		|=> fl.q[`CHGST_SAFETY_BIT])
		else $error("safety flag dropped without toggle");
	chk_wake1_clear: assert property (s_fault_rd ##0 !first_wake_met |=>
		!fl.q[`CHGST_WAKE1_BIT])
		else $error("wake one not cleared by read");
	chk_wake2_clear: assert property (s_fault_rd ##0 !second_wake_met |=>
		!fl.q[`CHGST_WAKE2_BIT])
		else $error("wake two not cleared by read");
	chk_read_answer: assert property (clk_en && reg_rd |=> reg_rvalid ##1
		(reg_rvalid == ($past(reg_rd) || !$past(clk_en))))
		else $error("read answer missing");
	chk_write_inert: assert property (clk_en && reg_wr && !reg_rd && !ce_toggle
		&& fl.set == 3'h0 |=> fl.q == $past(fl.q))
		else $error("write changed a flag");
endmodule : chgst_top

// file: tb/chgst_host.sv
// Purpose: Host model that reads and writes the status registers
// Assumes: Tasks are called from the bench; strobes change 1 ns after clk rises
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module chgst_host (
	// Clock
	input  wire logic       clk,
	// Strobes toward the block
	output logic [7:0]      reg_addr,
	output logic            reg_rd,
	output logic            reg_wr,
	output logic [7:0]      reg_wdata,
	// Answer from the block
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// Idle bus at time zero
	initial begin
		reg_addr  = 8'h00;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
	end

	// One read; unknown data if the answer never comes, so a hang cannot pass
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd   = 1'b1;
		@(posedge clk);
		#1;
		reg_rd   = 1'b0;
		reg_addr = ~a;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
	endtask : read_reg

	// mapped offsets only
	// One write pulse; the bench only aims it at the two status offsets
	task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		reg_addr  = a;
		reg_wdata = v;
		reg_wr    = 1'b1;
		@(posedge clk);
		#1;
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~v;
	endtask : write_reg
endmodule : chgst_host

// file: tb/charger_status_registers_tb_top.sv
// Purpose: Self-checking bench of the charger status registers
// Assumes: Pins settle within three clocks of a change
// Notes:   clk_en is dropped once to show that pins and flags freeze
`timescale 1ns/1ps
module charger_status_registers_tb_top;
	logic                    clk;        // Block clock
	logic                    rst_n;      // Synchronous reset
	logic                    clk_en;     // Clock enable
	logic [8:0]              pins;       // open,ilim,dip,vin,therm,pgood,ovp,buvlo,ce
	chgst_pkg::chgst_phase_t phase;      // Charge phase input
	chgst_pkg::chgst_zone_t  zone;       // Thermistor zone input
	logic [2:0]              ev;         // safety, wake1, wake2 pulses
	logic [2:0]              flags;      // Expected sticky flags
	logic [7:0]              reg_addr;
	logic                    reg_rd;
	logic                    reg_wr;
	logic [7:0]              reg_wdata;
	logic [7:0]              reg_rdata;
	logic                    reg_rvalid;
	logic [7:0]              d;          // Read result
	int                      error_cnt;
	int                      checks;

	chgst_host host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	chgst_top dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.thermistor_pin_open(pins[8]), .input_current_limiting(pins[7]), .supply_dip_limiting(pins[6]),
		.input_voltage_limiting(pins[5]), .thermal_regulating(pins[4]), .input_power_good(pins[3]),
		.input_overvoltage(pins[2]), .battery_undervoltage(pins[1]), .charge_enable(pins[0]),
		.charge_phase(phase), .thermistor_zone(zone), .safety_timer_expired(ev[2]),
		.first_wake_met(ev[1]), .second_wake_met(ev[0]));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare and count; four-state so an unknown never matches
	task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check_val

	// Idle cycles, ending 1 ns after an edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// Read both registers against the expected images
	task automatic check_both();
		host.read_reg(8'h00, d);
		check_val(d, {pins[8], phase, pins[7:3]});
		host.read_reg(8'h01, d);
		check_val(d, {pins[2:1], 1'b0, zone, flags});
		flags[1:0] = 2'b00;
	endtask : check_both

	// One-cycle event pulse, then wait for the flag
	task automatic pulse(input logic [2:0] which);
		ev = which;
		cyc(1);
		ev = 3'h0;
		flags = flags | which;
		cyc(1);
	endtask : pulse

	// Every pin but charge enable alone, every phase and zone code
	task automatic t_fields();
		for (int b = 1; b < 9; b++) begin
			pins = 9'h001 << b;
			cyc(3);
			check_both();
		end
		pins = 9'h000;
		for (int i = 0; i < 4; i++) begin
			phase = chgst_pkg::chgst_phase_t'(i[1:0]);
			zone  = chgst_pkg::chgst_zone_t'(i[1:0]);
			cyc(1);
			check_both();
		end
	endtask : t_fields

	// Wake flags set on event and clear on read
	task automatic t_wake();
		pulse(3'h2);
		host.read_reg(8'h01, d);
		check_val(d, {3'h0, zone, 3'h2});
		host.read_reg(8'h01, d);
		check_val(d, {3'h0, zone, 3'h0});
		pulse(3'h1);
		host.read_reg(8'h01, d);
		check_val(d, {3'h0, zone, 3'h1});
		flags = 3'h0;
		check_both();
	endtask : t_wake

	// Safety flag survives reads and writes, clears on enable toggle
	task automatic t_safety();
		pulse(3'h4);
		check_both();
		host.write_reg(8'h01, 8'hFF);
		host.write_reg(8'h00, 8'hFF);
		check_both();
		pins[0] = ~pins[0];
		flags = 3'h0;
		cyc(5);
		check_both();
	endtask : t_safety

	// Low clk_en: pin change and event pulse must not be taken
	task automatic t_freeze();
		clk_en  = 1'b0;
		pins[8] = 1'b1;
		ev      = 3'h1;
		cyc(3);
		ev      = 3'h0;
		clk_en  = 1'b1;
		// Chain was frozen, so the open pin is not seen yet
		host.read_reg(8'h00, d);
		check_val(d, {1'b0, phase, 5'h00});
		check_both();
	endtask : t_freeze

	// Mid-run reset clears every flag
	task automatic t_reset();
		pulse(3'h7);
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		flags = 3'h0;
		cyc(3);
		check_both();
	endtask : t_reset

	// Main sequence
	initial begin
		error_cnt = 0;
		checks    = 0;
		rst_n     = 1'b0;
		clk_en    = 1'b1;
		pins      = 9'h000;
		ev        = 3'h0;
		flags     = 3'h0;
		phase     = chgst_pkg::CHGST_PH_IDLE;
		zone      = chgst_pkg::CHGST_TZ_NORMAL;
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		cyc(3);
		check_both();
		host.read_reg(8'h05, d);
		check_val(d, 8'h00);
		t_fields();
		t_wake();
		t_safety();
		t_freeze();
		t_reset();
		give_verdict();
	end

	// Watchdog at 20000 cycles, well beyond the roughly 150 cycles the tests need
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end

	// Counts, verdict and end of run
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
endmodule : charger_status_registers_tb_top
